/* File: logic/cieec_pkg.sv */
`default_nettype none
package cieec_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] OFS_ENABLE  = 8'h00;
   localparam logic [7:0] OFS_FLAGS   = 8'h04;
   localparam logic [7:0] OFS_CAPTURE = 8'h08;
   localparam logic [7:0] OFS_COMMAND = 8'h0C;

   // enable and flag bit positions, shared by both registers
   localparam int BIT_RX_PENDING = 0;
   localparam int BIT_TX_BUF1    = 1;
   localparam int BIT_ERR_WARN   = 2;
   localparam int BIT_OVERRUN    = 3;
   localparam int BIT_ERR_PASS   = 5;
   localparam int BIT_ARB_LOSS   = 6;
   localparam int BIT_BUS_FAULT  = 7;
   localparam int BIT_IDENT_RX   = 8;
   localparam int BIT_TX_BUF2    = 9;
   localparam int BIT_TX_BUF3    = 10;
   localparam int NUM_BITS       = 11;
   localparam logic [10:0] IE_MASK  = 11'h7EF;
   localparam logic [10:0] IE_RESET = 11'h000;

   // capture register layout
   localparam int CAP_POS_LSB  = 0;
   localparam int CAP_KIND_LSB = 6;
   // command register: release receive buffer
   localparam int CMD_RELEASE_BIT = 0;

   // bus error kinds
   localparam logic [1:0] KIND_BIT   = 2'h0;
   localparam logic [1:0] KIND_FORM  = 2'h1;
   localparam logic [1:0] KIND_STUFF = 2'h2;
   localparam logic [1:0] KIND_OTHER = 2'h3;

   // frame position codes
   localparam logic [4:0] POS_ID_28_21   = 5'h02;
   localparam logic [4:0] POS_SOF        = 5'h03;
   localparam logic [4:0] POS_RTR_STD    = 5'h04;
   localparam logic [4:0] POS_IDE        = 5'h05;
   localparam logic [4:0] POS_ID_17_13   = 5'h07;
   localparam logic [4:0] POS_CRC        = 5'h08;
   localparam logic [4:0] POS_RSV_BIT0   = 5'h09;
   localparam logic [4:0] POS_DATA       = 5'h0A;
   localparam logic [4:0] POS_DLC        = 5'h0B;
   localparam logic [4:0] POS_RTR_EXT    = 5'h0C;
   localparam logic [4:0] POS_RSV_BIT1   = 5'h0D;
   localparam logic [4:0] POS_ID_4_0     = 5'h0E;
   localparam logic [4:0] POS_ID_12_5    = 5'h0F;
   localparam logic [4:0] POS_ACT_FLAG   = 5'h11;
   localparam logic [4:0] POS_INTERMISS  = 5'h12;
   localparam logic [4:0] POS_TOL_DOM    = 5'h13;
   localparam logic [4:0] POS_PASS_FLAG  = 5'h16;
   localparam logic [4:0] POS_ERR_DELIM  = 5'h17;
   localparam logic [4:0] POS_CRC_DELIM  = 5'h18;
   localparam logic [4:0] POS_ACK_SLOT   = 5'h19;
   localparam logic [4:0] POS_EOF        = 5'h1A;
   localparam logic [4:0] POS_ACK_DELIM  = 5'h1B;
   localparam logic [4:0] POS_OVL_FLAG   = 5'h1C;
   // one bit per code, set where the code names a frame position
   localparam logic [31:0] POS_VALID_MASK = 32'h1FCEFFBC;
   localparam logic [4:0]  POS_RESET      = POS_SOF;
endpackage
`default_nettype wire

/* File: logic/cieec_core.sv */
`timescale 1ns/1ps
`default_nettype none
module cieec_core (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   // protocol engine events and status
   input  wire logic [2:0]  tx_released_in,
   input  wire logic        ident_rx_in,
   input  wire logic        bus_err_in,
   input  wire logic [1:0]  bus_err_kind_in,
   input  wire logic [4:0]  bus_err_pos_in,
   input  wire logic        arb_lost_in,
   input  wire logic        err_passive_in,
   input  wire logic        overrun_in,
   input  wire logic        err_status_in,
   input  wire logic        bus_off_in,
   input  wire logic        rx_nonempty_in,
   // outputs to the rest of the controller
   output logic             rx_release_out,
   output logic [10:0]      irq_flags_out,
   output logic [1:0]       bus_error_kind_out,
   output logic [4:0]       error_position_code_out
);

   ////////////////////////////////////////////////////////////////////
   // bus timing, as the rest of the controller sees it
   // - a request is taken on the edge where cyc and stb are high and ack is low
   // - ack follows one cycle later and lasts exactly one cycle
   // - the master must drop stb for a cycle after ack, or the same
   //   request is taken again; a wasted cycle buys a simpler slave
   // - read data is latched at the take edge and holds until the next read
   // - unmapped offsets read as zero and swallow writes, but are still acked,
   //   so a stray access can never stall the bus
   //
   // event timing
   // - pulse sources (ident, bus error, arbitration, overrun) count each
   //   high cycle; the engine must not stretch them
   // - level sources (tx release, passive, warning) are compared with their
   //   value one cycle earlier; the trackers reset low, so a level already
   //   high after reset shows one edge, which the cleared enables mask
   // - a flag is set one cycle after its event, only if the enable was
   //   already one at the event; events seen while disabled are forgotten
   // - reading the flag register clears every flag but the receive flag;
   //   an event in that same cycle wins, so no event is lost to a read
   //
   // receive flag
   // - not sticky: it follows buffer level and enable
   // - a release command forces it low for two cycles, which gives the
   //   buffer time to move on before its level is trusted again
   //
   // capture
   // - kind is stored on every bus error
   // - position is stored only for a code that names a frame position;
   //   a reserved code keeps the previous one, so software never reads one

   typedef struct packed {
      logic [10:0] can_interrupt_enable;
      logic [10:0] flags;
      logic [1:0]  bus_error_kind;
      logic [4:0]  error_position_code;
      logic [2:0]  tx_prev;
      logic        passive_prev;
      logic        status_prev;
      logic        bus_off_prev;
      logic        rx_hold;
      logic        rx_release;
      logic        ack;
      logic [31:0] rdata;
   } cieec_state_s;

   cieec_state_s state_reg;
   cieec_state_s state_next;

   ////////////////////////////////////////////////////////////////////
   // event vector, one entry per flag position
   logic [10:0] event_hit;
   always_comb begin
      event_hit = 11'h000;
      // transmit buffers: only the rising edge of the release level counts
      event_hit[cieec_pkg::BIT_TX_BUF3] = tx_released_in[2] & ~state_reg.tx_prev[2];
      event_hit[cieec_pkg::BIT_TX_BUF2] = tx_released_in[1] & ~state_reg.tx_prev[1];
      event_hit[cieec_pkg::BIT_TX_BUF1] = tx_released_in[0] & ~state_reg.tx_prev[0];
      // pulse sources: every high cycle is one event
      event_hit[cieec_pkg::BIT_IDENT_RX]  = ident_rx_in;
      event_hit[cieec_pkg::BIT_BUS_FAULT] = bus_err_in;
      event_hit[cieec_pkg::BIT_ARB_LOSS]  = arb_lost_in;
      // either direction of the passive state counts
      event_hit[cieec_pkg::BIT_ERR_PASS] = err_passive_in ^ state_reg.passive_prev;
      event_hit[cieec_pkg::BIT_OVERRUN]  = overrun_in;
      event_hit[cieec_pkg::BIT_ERR_WARN] = (err_status_in ^ state_reg.status_prev)
                                         | (bus_off_in ^ state_reg.bus_off_prev);
      // level source, held off for one cycle after a release so the buffer can update
      event_hit[cieec_pkg::BIT_RX_PENDING] = rx_nonempty_in & ~state_reg.rx_hold;
   end

   ////////////////////////////////////////////////////////////////////
   // bus decode
   // a request already acked is not taken again; this keeps one access
   // to one ack even if the master is slow to drop stb, as long as it
   // drops it in the cycle after ack, before the next request
   logic take;
   logic is_write;
   logic is_read;
   logic [31:0] wmask;
   always_comb begin
      take     = wb_cyc_in & wb_stb_in & ~state_reg.ack;
      is_write = take & wb_we_in;
      is_read  = take & ~wb_we_in;
      wmask    = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   end

   ////////////////////////////////////////////////////////////////////
   // frame position decode; every code that names a position is listed,
   // the reserved ones fall to the default so they can never be captured
   logic pos_defined;
   always_comb begin
      case (bus_err_pos_in)
         cieec_pkg::POS_SOF,
         cieec_pkg::POS_DLC,
         cieec_pkg::POS_DATA,
         cieec_pkg::POS_CRC: begin
            pos_defined = 1'b1;
         end
         cieec_pkg::POS_ID_28_21,
         cieec_pkg::POS_ID_17_13,
         cieec_pkg::POS_ID_4_0,
         cieec_pkg::POS_ID_12_5: begin
            pos_defined = 1'b1;
         end
         cieec_pkg::POS_RTR_STD,
         cieec_pkg::POS_RTR_EXT: begin
            pos_defined = 1'b1;
         end
         cieec_pkg::POS_ACT_FLAG,
         cieec_pkg::POS_PASS_FLAG,
         cieec_pkg::POS_OVL_FLAG: begin
            pos_defined = 1'b1;
         end
         cieec_pkg::POS_IDE,
         cieec_pkg::POS_RSV_BIT0,
         cieec_pkg::POS_RSV_BIT1,
         cieec_pkg::POS_INTERMISS,
         cieec_pkg::POS_TOL_DOM,
         cieec_pkg::POS_ERR_DELIM,
         cieec_pkg::POS_CRC_DELIM,
         cieec_pkg::POS_ACK_SLOT,
         cieec_pkg::POS_EOF,
         cieec_pkg::POS_ACK_DELIM: begin
            pos_defined = 1'b1;
         end
         default: begin
            pos_defined = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next state
   // priority inside one cycle, lowest first:
   // - hold everything, then track the level inputs
   // - bus read latches data, bus writes update enable or command
   // - flag clear by read, then flag set by event, so the set wins
   // - capture on a bus error, independent of the bus
   always_comb begin
      state_next = state_reg;
      state_next.ack = take;
      state_next.tx_prev      = tx_released_in;
      state_next.passive_prev = err_passive_in;
      state_next.status_prev  = err_status_in;
      state_next.bus_off_prev = bus_off_in;
      state_next.rx_release   = 1'b0;
      state_next.rx_hold      = 1'b0;

      // read data is latched at the take edge; unmapped reads give zero
      // map: enable at the first word, flags at the second, capture at
      // the third; the command word is write only and reads as zero
      if (is_read) begin
         case (wb_adr_in)
            cieec_pkg::OFS_ENABLE: begin
               state_next.rdata = {21'h0, state_reg.can_interrupt_enable};
            end
            cieec_pkg::OFS_FLAGS: begin
               state_next.rdata = {21'h0, state_reg.flags};
            end
            cieec_pkg::OFS_CAPTURE: begin
               state_next.rdata = 32'h00000000;
               state_next.rdata[cieec_pkg::CAP_POS_LSB +: 5]  = state_reg.error_position_code;
               state_next.rdata[cieec_pkg::CAP_KIND_LSB +: 2] = state_reg.bus_error_kind;
            end
            default: begin
               state_next.rdata = 32'h00000000;
            end
         endcase
      end

      // enable writes honour byte lanes; reserved bits never store
      if (is_write && wb_adr_in == cieec_pkg::OFS_ENABLE) begin
         state_next.can_interrupt_enable =
            (state_reg.can_interrupt_enable & ~wmask[10:0])
            | (wb_dat_in[10:0] & wmask[10:0] & cieec_pkg::IE_MASK);
      end

      // release receive buffer command
      if (is_write && wb_adr_in == cieec_pkg::OFS_COMMAND
          && wb_sel_in[0] && wb_dat_in[cieec_pkg::CMD_RELEASE_BIT]) begin
         state_next.rx_release = 1'b1;
         state_next.rx_hold    = 1'b1;
      end

      // flag update: read clears all but the receive flag, a new event wins
      // the enable is the one held before this edge, so an enable write
      // and an event in one cycle do not set the flag
      for (int i = 0; i < cieec_pkg::NUM_BITS; i++) begin
         if (i == cieec_pkg::BIT_RX_PENDING) begin
            // receive flag follows the buffer level, dropped on release
            state_next.flags[i] = event_hit[i] & state_reg.can_interrupt_enable[i]
                                & ~state_next.rx_hold;
         end else begin
            if (is_read && wb_adr_in == cieec_pkg::OFS_FLAGS) begin
               state_next.flags[i] = 1'b0;
            end
            if (event_hit[i] && state_reg.can_interrupt_enable[i]) begin
               state_next.flags[i] = 1'b1;
            end
         end
      end

      // capture kind and position; reserved positions leave the field alone
      if (bus_err_in) begin
         state_next.bus_error_kind = bus_err_kind_in;
         if (pos_defined) begin
            state_next.error_position_code = bus_err_pos_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   // reset is synchronous; every field gets a constant so nothing leaks
   // from before reset, and the edge trackers start low, matching an
   // idle engine
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state_reg <= '0;
         state_reg.can_interrupt_enable <= cieec_pkg::IE_RESET;
         state_reg.error_position_code  <= cieec_pkg::POS_RESET;
         state_reg.bus_error_kind       <= cieec_pkg::KIND_BIT;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign wb_dat_out              = state_reg.rdata;
   assign wb_ack_out              = state_reg.ack;
   assign rx_release_out          = state_reg.rx_release;
   assign irq_flags_out           = state_reg.flags;
   assign bus_error_kind_out      = state_reg.bus_error_kind;
   assign error_position_code_out = state_reg.error_position_code;

endmodule
`default_nettype wire

/* File: verif/cieec_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cieec_chk (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // watched ports
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_ack_out,
   input  wire logic [2:0]  tx_released_in,
   input  wire logic        bus_err_in,
   input  wire logic [1:0]  bus_err_kind_in,
   input  wire logic        rx_nonempty_in,
   input  wire logic        rx_release_out,
   input  wire logic [10:0] irq_flags_out,
   input  wire logic [1:0]  bus_error_kind_out,
   input  wire logic [4:0]  error_position_code_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   // a taken request gets exactly one ack cycle
   sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
   sequence s_pulse; wb_ack_out ##1 !wb_ack_out; endsequence
   a_ack_one_pulse: assert property (s_take |=> s_pulse) else $error("ack pulse");
   // flags only rise after their cause
   a_tx1_rise_edge: assert property ($rose(irq_flags_out[1]) |->
      $past(tx_released_in[0]) && !$past(tx_released_in[0], 2)) else $error("tx1 flag");
   a_fault_flag_cause: assert property ($rose(irq_flags_out[7]) |->
      $past(bus_err_in)) else $error("bus fault flag");
   a_rx_flag_level: assert property (irq_flags_out[0] |->
      $past(rx_nonempty_in)) else $error("rx flag");
   a_res_flag_zero: assert property (irq_flags_out[4] == 1'b0) else $error("bit 4");
   // capture kind follows the error, the position never holds a reserved code; release lasts one cycle
   a_kind_capture: assert property (bus_err_in |=>
      bus_error_kind_out == $past(bus_err_kind_in)) else $error("kind");
   a_pos_defined: assert property (
      cieec_pkg::POS_VALID_MASK[error_position_code_out]) else $error("reserved code");
   a_release_single: assert property (rx_release_out |=> !rx_release_out)
      else $error("release pulse");
endmodule
bind cieec_core cieec_chk chk_u (.clock_in(clock_in), .reset_in(reset_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .tx_released_in(tx_released_in), .bus_err_in(bus_err_in),
   .bus_err_kind_in(bus_err_kind_in), .rx_nonempty_in(rx_nonempty_in),
   .rx_release_out(rx_release_out), .irq_flags_out(irq_flags_out),
   .bus_error_kind_out(bus_error_kind_out), .error_position_code_out(error_position_code_out));
`default_nettype wire

/* File: verif/cieec_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module cieec_peer (
   // clock and random source
   input  wire logic        clock_in,
   input  wire logic [15:0] rnd_in,
   // engine pulses and levels
   output logic      [2:0]  tx_out,
   output logic             ident_out,
   output logic             berr_out,
   output logic      [6:0]  kp_out,
   output logic             arb_out,
   output logic             ovr_out,
   output logic      [3:0]  lvl_out
);
   // defined at time zero so the first edge compares are known
   initial {tx_out, ident_out, berr_out, kp_out, arb_out, ovr_out, lvl_out} = '0;
   // pulses last a cycle; levels move on some cycles only, keeping edges sparse
   always @(posedge clock_in) begin
      {ident_out, berr_out, arb_out} <= {&rnd_in[1:0], &rnd_in[3:2], &rnd_in[12:11]};
      ovr_out <= &rnd_in[14:13];
      kp_out <= rnd_in[10:4]; // changes every cycle, only meaningful with berr
      if (rnd_in[15]) {tx_out, lvl_out} <= {tx_out, lvl_out} ^ rnd_in[6:0];
   end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clock_in = 1'b0, reset_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, lvl;
   logic [31:0] wdat = 32'h0, rdat, rd_m, rv;
   logic [15:0] rnd = 16'h0021, m;
   logic [10:0] flags, en_m, fl_m, ev;
   logic [6:0]  kp, cap_m;
   logic [2:0]  tx, ptx;
   logic [3:0]  plvl;
   logic [1:0]  kind;
   logic [4:0]  pos;
   logic        ack, ident, berr, arb, ovr, rel, rh, rel_m, take, relt;
   int          fail_count = 0, cmp_count = 0;
   //////////////////////////////////////////////////////////////////
   always #12.5 clock_in = ~clock_in;
   always @(posedge clock_in) rnd <= lfsr(rnd);
   cieec_peer peer_u (.clock_in(clock_in), .rnd_in(rnd), .tx_out(tx), .ident_out(ident),
      .berr_out(berr), .kp_out(kp), .arb_out(arb), .ovr_out(ovr), .lvl_out(lvl));
   cieec_core dut_u (.clock_in(clock_in), .reset_in(reset_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .tx_released_in(tx), .ident_rx_in(ident),
      .bus_err_in(berr), .bus_err_kind_in(kp[6:5]), .bus_err_pos_in(kp[4:0]),
      .arb_lost_in(arb), .err_passive_in(lvl[3]), .overrun_in(ovr), .err_status_in(lvl[2]),
      .bus_off_in(lvl[1]), .rx_nonempty_in(lvl[0]), .rx_release_out(rel),
      .irq_flags_out(flags), .bus_error_kind_out(kind), .error_position_code_out(pos));
   //////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one classic cycle; waits for ack as long as it takes, the watchdog ends a dead wait
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s,
                           input logic [31:0] d);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      @(posedge clock_in);
      while (ack !== 1'b1) begin
         @(posedge clock_in);
      end
      if (!w) check(rdat, rd_m);
      {cyc, stb} <= 2'b00;
      @(posedge clock_in);
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   // reference model; enables act with the value held before this edge
   always @(posedge clock_in) begin
      take = cyc && stb && !ack;
      relt = take && we && adr == cieec_pkg::OFS_COMMAND && sel[0] && wdat[0];
      ev = {tx[2:1] & ~ptx[2:1], ident, berr, arb, lvl[3] ^ plvl[3], 1'b0, ovr,
            |(lvl[2:1] ^ plvl[2:1]), tx[0] & ~ptx[0], 1'b0};
      m = {{8{sel[1]}}, {8{sel[0]}}};
      case (adr)
         cieec_pkg::OFS_ENABLE:  rv = {21'h0, en_m};
         cieec_pkg::OFS_FLAGS:   rv = {21'h0, fl_m};
         cieec_pkg::OFS_CAPTURE: rv = {24'h0, cap_m[6:5], 1'b0, cap_m[4:0]};
         default:                rv = 32'h0;
      endcase
      if (take && !we) rd_m <= rv;
      if (reset_in) begin
         {en_m, fl_m, ptx, plvl, rh, rel_m} <= '0;
         cap_m <= {2'h0, cieec_pkg::POS_RESET};
      end else begin
         if (take && we && adr == cieec_pkg::OFS_ENABLE)
            en_m <= (en_m & ~m[10:0]) | (wdat[10:0] & m[10:0] & cieec_pkg::IE_MASK);
         fl_m[10:1] <= (take && !we && adr == cieec_pkg::OFS_FLAGS ? 10'h000 : fl_m[10:1])
                       | (ev[10:1] & en_m[10:1]);
         fl_m[0] <= lvl[0] && en_m[0] && !rh && !relt;
         {rh, rel_m, ptx, plvl} <= {relt, relt, tx, lvl};
         if (berr) cap_m[6:5] <= kp[6:5];
         if (berr && cieec_pkg::POS_VALID_MASK[kp[4:0]]) cap_m[4:0] <= kp[4:0];
      end
   end
   // outputs against the model once per cycle, away from the edge
   always @(negedge clock_in) begin
      if (!reset_in) begin
         check({21'h0, flags}, {21'h0, fl_m});
         check({31'h0, rel}, {31'h0, rel_m});
         check({25'h0, kind, pos}, {25'h0, cap_m});
      end
   end
   // two passes, the second after a reset in mid-run
   initial begin
      for (int k = 0; k < 2; k++) begin
         reset_in <= 1'b1;
         repeat (2) @(posedge clock_in);
         reset_in <= 1'b0;
         @(posedge clock_in);
         wb_cycle(1'b0, cieec_pkg::OFS_ENABLE, 4'hF, 32'h0);
         wb_cycle(1'b1, cieec_pkg::OFS_ENABLE, 4'hF, 32'hFFFFFFFF);
         wb_cycle(1'b0, cieec_pkg::OFS_ENABLE, 4'hF, 32'h0);
         for (int i = 0; i < 600; i++) begin
            wb_cycle(rnd[0], {3'h0, rnd[3:1], 2'h0}, rnd[7:4], {lfsr(rnd), rnd});
         end
      end
      print_verdict();
   end
   // hang guard, far beyond the few thousand cycles the passes need
   initial begin
      #1000000;
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
